// File: lrcb_pkg.sv
// Purpose: shared constants for the lockout, reset and chain baseline manager
// Assumes: single clock domain, clk_sys at 200 MHz
// Notes: chain composition arrives as one packed word per chain
`default_nettype none
package lrcb_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned DEBOUNCE_US = 1;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned CNT_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int unsigned N_IN = 4;
  localparam int unsigned N_OUT = 2;
  localparam int unsigned N_CHAIN = 2;
  localparam int unsigned COMP_W = 32;
  localparam logic [1:0] DB_IDLE = 2'h0;
  // startup sequencer states, one-hot
  typedef enum logic [3:0] {
    LRCB_ST_CONFIG = 4'h1,
    LRCB_ST_QUERY = 4'h2,
    LRCB_ST_WAIT_ACC = 4'h4,
    LRCB_ST_RUN = 4'h8
  } lrcb_state_t;
endpackage : lrcb_pkg
`default_nettype wire

// File: lrcb_manager.sv
// Purpose: fault lockout, reset handling and chain baseline tracking
// Assumes: pins are asynchronous to clk_sys; composition inputs are synchronous
// Notes: outputs come straight from flip-flops
//
// Functional notes
// - input lockout held until repaired and input cycled off then on.
// - output lockout cleared only by repair and its fault-clear reset cycle.
// - system faults cleared by cycling the designated system reset input.
// - exactly one reset source may be the system reset; others rejected.
// - safety-critical fault forces lockout and affected outputs off.
// - system reset with fault still present re-enters lockout immediately.
// - after new configuration, outputs off until a system reset.
// - press-control fault needs system reset, not input or output reset.
// - internal fault ignores system reset; only power cycle recovers.
// - non-monitored reset turns outputs on when reset becomes active.
// - outputs depend only on chain switching outputs, never diagnostics.
// - with discovery enabled, query every chain's count, positions and types.
// - at power-up store each chain's composition as baseline and report it.
// - no change flag for differences from before power loss.
// - manual baselining raises request flag; baseline set on partner accept.
// - without manual baselining, present composition becomes baseline.
// - manual-baselining and discovery settings are global for all chains.
// - with discovery, stored configuration follows newly detected compositions.
// - report composition changes with the chain identified.
// - chain change flag set to one until partner acknowledges.
`default_nettype none
module lrcb_manager
  import lrcb_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [lrcb_pkg::N_IN-1:0] input_pin,
  input wire logic [lrcb_pkg::N_IN-1:0] input_fault,
  input wire logic [lrcb_pkg::N_IN-1:0] reset_pin,
  input wire logic [lrcb_pkg::N_IN-1:0] reset_is_system,
  input wire logic [lrcb_pkg::N_IN-1:0] reset_non_monitored,
  input wire logic [lrcb_pkg::N_OUT-1:0] fault_clear_node_sel_0,
  input wire logic [lrcb_pkg::N_OUT-1:0] fault_clear_node_sel_1,
  input wire logic [lrcb_pkg::N_OUT-1:0] output_fault,
  input wire logic [lrcb_pkg::N_OUT-1:0] output_demand,
  input wire logic [lrcb_pkg::N_IN-1:0] output_input_map,
  input wire logic sys_fault,
  input wire logic press_fault,
  input wire logic internal_fault,
  input wire logic virtual_reset,
  input wire logic virtual_reset_is_system,
  input wire logic config_loaded,
  input wire logic chain_auto_discovery,
  input wire logic startup_baseline_confirm,
  input wire logic baseline_accept,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_ack,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_comp_valid,
  input wire logic [lrcb_pkg::N_CHAIN*lrcb_pkg::COMP_W-1:0] chain_comp,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_diagnostic_info,
  output logic [lrcb_pkg::N_OUT-1:0] safety_switching_output,
  output logic [lrcb_pkg::N_IN-1:0] input_lockout,
  output logic [lrcb_pkg::N_OUT-1:0] output_lockout,
  output logic system_lockout,
  output logic config_error,
  output logic chain_query,
  output logic baseline_request_flag,
  output logic [lrcb_pkg::N_CHAIN-1:0] chain_changed,
  output logic [lrcb_pkg::N_CHAIN*lrcb_pkg::COMP_W-1:0] chain_baseline
);
  // --------------------------------------------------------------------
  // input synchronisers and debounce
  // --------------------------------------------------------------------
  localparam int unsigned NS = 2 * N_IN;
  logic [NS-1:0] meta_reg, sync_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {reset_pin, input_pin};
      sync_reg <= meta_reg;
    end
  end

  logic [NS-1:0] stable_reg, stable_next, rise, fall;
  logic [NS-1:0][CNT_W-1:0] cnt_reg, cnt_next;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_deb
      always_comb begin
        cnt_next[gi] = cnt_reg[gi];
        stable_next[gi] = stable_reg[gi];
        if (sync_reg[gi] == stable_reg[gi]) begin
          cnt_next[gi] = '0;
        end else if (cnt_reg[gi] >= CNT_W'(DEB_CYC - 1)) begin
          cnt_next[gi] = '0;
          stable_next[gi] = sync_reg[gi];
        end else begin
          cnt_next[gi] = cnt_reg[gi] + CNT_W'(1);
        end
      end
      assign rise[gi] = stable_next[gi] & ~stable_reg[gi];
      assign fall[gi] = ~stable_next[gi] & stable_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      stable_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      stable_reg <= stable_next;
    end
  end

  logic [N_IN-1:0] in_lvl, in_on, in_off, rst_rise, rst_fall;
  assign in_lvl = stable_reg[N_IN-1:0];
  assign in_on = rise[N_IN-1:0];
  assign in_off = fall[N_IN-1:0];
  assign rst_rise = rise[NS-1:N_IN];
  assign rst_fall = fall[NS-1:N_IN];

  // --------------------------------------------------------------------
  // reset cycle tracking
  // --------------------------------------------------------------------
  // armed once a debounced active level is seen; cycle completes on release
  logic [N_IN-1:0] armed_reg, armed_next, cyc_done, cyc_edge;
  always_comb begin
    armed_next = (armed_reg | rst_rise) & ~rst_fall;
    cyc_done = armed_reg & rst_fall;
    // non-monitored resets act on the active edge
    cyc_edge = (cyc_done & ~reset_non_monitored) | (rst_rise & reset_non_monitored);
  end

  // exactly one system reset source allowed
  logic [N_IN:0] sys_sel;
  logic one_sys;
  assign sys_sel = {virtual_reset_is_system, reset_is_system};
  assign one_sys = (sys_sel != '0) && ((sys_sel & (sys_sel - (N_IN + 1)'(1))) == '0);

  logic vr_reg, sys_cycle;
  assign sys_cycle = one_sys && (((cyc_edge & reset_is_system) != '0) ||
                     (virtual_reset_is_system && vr_reg && !virtual_reset));

  // --------------------------------------------------------------------
  // lockouts
  // --------------------------------------------------------------------
  logic [N_IN-1:0] in_lo_reg, in_lo_next, in_off_seen_reg, in_off_seen_next;
  logic [N_OUT-1:0] out_lo_reg, out_lo_next, out_clear;
  logic sys_lo_reg, sys_lo_next, press_reg, press_next, intl_reg, intl_next;
  logic cfg_wait_reg, cfg_wait_next;

  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_fr
      // each output picks its fault-clear node from the two reset inputs
      assign out_clear[gi] = (cyc_edge[0] & fault_clear_node_sel_0[gi]) |
                             (cyc_edge[1] & fault_clear_node_sel_1[gi]);
    end
  endgenerate

  always_comb begin
    in_off_seen_next = in_off_seen_reg | (in_lo_reg & in_off & ~input_fault);
    in_lo_next = in_lo_reg;
    // set beats clear for every latched fault
    for (int i = 0; i < N_IN; i++) begin
      if (input_fault[i]) begin
        in_lo_next[i] = 1'b1;
        in_off_seen_next[i] = 1'b0;
      end else if (in_lo_reg[i] && in_off_seen_reg[i] && in_on[i]) begin
        in_lo_next[i] = 1'b0;
        in_off_seen_next[i] = 1'b0;
      end
    end
    out_lo_next = output_fault | (out_lo_reg & ~out_clear);
    press_next = press_fault | (press_reg & ~sys_cycle);
    // a reset with the cause still present leaves the lockout set
    sys_lo_next = sys_fault | press_fault | (sys_lo_reg & ~sys_cycle);
    intl_next = intl_reg | internal_fault;
    cfg_wait_next = config_loaded | (cfg_wait_reg & ~sys_cycle);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_reg <= '0;
      vr_reg <= 1'b0;
      in_lo_reg <= '0;
      in_off_seen_reg <= '0;
      out_lo_reg <= '0;
      press_reg <= 1'b0;
      sys_lo_reg <= 1'b0;
      intl_reg <= 1'b0;
      cfg_wait_reg <= 1'b1;
    end else begin
      armed_reg <= armed_next;
      vr_reg <= virtual_reset;
      in_lo_reg <= in_lo_next;
      in_off_seen_reg <= in_off_seen_next;
      out_lo_reg <= out_lo_next;
      press_reg <= press_next;
      sys_lo_reg <= sys_lo_next;
      intl_reg <= intl_next;
      cfg_wait_reg <= cfg_wait_next;
    end
  end

  // --------------------------------------------------------------------
  // safety outputs
  // --------------------------------------------------------------------
  logic [N_OUT-1:0] sso_next;
  logic global_block;
  assign global_block = sys_lo_next | press_next | intl_next | cfg_wait_next | ~one_sys;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      // diagnostic info is deliberately not part of this term
      assign sso_next[gi] = output_demand[gi] & ~global_block & ~out_lo_next[gi] &
                            ~((in_lo_next | ~in_lvl) != '0 && output_input_map != '0 &&
                              ((in_lo_next | ~in_lvl) & output_input_map) != '0);
    end
  endgenerate

  // --------------------------------------------------------------------
  // chain discovery and baseline
  // --------------------------------------------------------------------
  lrcb_state_t st_reg, st_next;
  logic [N_CHAIN*COMP_W-1:0] base_next;
  logic [N_CHAIN-1:0] chg_next;
  logic req_next, query_next;
  always_comb begin
    st_next = st_reg;
    base_next = chain_baseline;
    chg_next = chain_changed & ~chain_ack;
    req_next = 1'b0;
    query_next = 1'b0;
    case (st_reg)
      LRCB_ST_CONFIG: begin
        if (chain_auto_discovery) begin
          st_next = LRCB_ST_QUERY;
        end
      end
      LRCB_ST_QUERY: begin
        query_next = 1'b1;
        if (&chain_comp_valid) begin
          if (startup_baseline_confirm) begin
            st_next = LRCB_ST_WAIT_ACC;
          end else begin
            base_next = chain_comp;
            st_next = LRCB_ST_RUN;
          end
        end
      end
      LRCB_ST_WAIT_ACC: begin
        req_next = 1'b1;
        query_next = 1'b1;
        if (baseline_accept) begin
          base_next = chain_comp;
          req_next = 1'b0;
          st_next = LRCB_ST_RUN;
        end
      end
      LRCB_ST_RUN: begin
        query_next = 1'b1;
        for (int c = 0; c < N_CHAIN; c++) begin
          if (chain_comp_valid[c] && chain_comp[c*COMP_W +: COMP_W] != chain_baseline[c*COMP_W +: COMP_W]) begin
            base_next[c*COMP_W +: COMP_W] = chain_comp[c*COMP_W +: COMP_W];
            chg_next[c] = 1'b1;
          end
        end
        if (!chain_auto_discovery) begin
          st_next = LRCB_ST_CONFIG;
        end
      end
      default: begin
        st_next = LRCB_ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // no memory of pre-power-off composition is kept
      st_reg <= LRCB_ST_CONFIG;
      chain_baseline <= '0;
      chain_changed <= '0;
      baseline_request_flag <= 1'b0;
      chain_query <= 1'b0;
      safety_switching_output <= '0;
      input_lockout <= '0;
      output_lockout <= '0;
      system_lockout <= 1'b0;
      config_error <= 1'b0;
    end else begin
      st_reg <= st_next;
      chain_baseline <= base_next;
      chain_changed <= chg_next;
      baseline_request_flag <= req_next;
      chain_query <= query_next;
      safety_switching_output <= sso_next;
      input_lockout <= in_lo_next;
      output_lockout <= out_lo_next;
      system_lockout <= sys_lo_next | intl_next;
      config_error <= ~one_sys;
    end
  end
endmodule // lrcb_manager
`default_nettype wire

// File: lrcb_properties.sv
// Purpose: concurrent checks on the lockout manager ports
// Assumes: single clock domain, rst async active high
// Notes: attached to every manager by the bind below
`default_nettype none
module lrcb_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [lrcb_pkg::N_IN-1:0] input_fault,
  input wire logic [lrcb_pkg::N_OUT-1:0] output_fault,
  input wire logic sys_fault,
  input wire logic press_fault,
  input wire logic baseline_accept,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_ack,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_comp_valid,
  input wire logic [lrcb_pkg::N_OUT-1:0] safety_switching_output,
  input wire logic [lrcb_pkg::N_IN-1:0] input_lockout,
  input wire logic [lrcb_pkg::N_OUT-1:0] output_lockout,
  input wire logic system_lockout,
  input wire logic config_error,
  input wire logic baseline_request_flag,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_changed
);
  timeunit 1ns;
  timeprecision 100ps;
  import lrcb_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // --------------------------------
  // lockouts and flags
  // --------------------------------
  AST_CFG_OFF: assert property (config_error && $past(config_error) |-> safety_switching_output == '0)
    else $error("outputs on with invalid reset setup");
  AST_SYS_LOCK: assert property (sys_fault || press_fault |=> system_lockout)
    else $error("system fault not locked");
  AST_SYS_HOLD: assert property (system_lockout && sys_fault |=> system_lockout)
    else $error("lockout released with fault present");
  AST_SYS_OFF: assert property (system_lockout && $past(system_lockout) |-> safety_switching_output == '0)
    else $error("outputs on during system lockout");
  AST_OUT_LOCK: assert property (output_fault[0] |=> output_lockout[0])
    else $error("output fault not locked");
  AST_OUT_OFF: assert property (output_lockout[1] && $past(output_lockout[1]) |-> !safety_switching_output[1])
    else $error("locked output still on");
  AST_IN_LOCK: assert property (input_fault[0] |=> input_lockout[0])
    else $error("input fault not locked");
  AST_CHG_HOLD: assert property (chain_changed[0] && !chain_ack[0] |=> chain_changed[0])
    else $error("change flag dropped without ack");
  AST_ACK_CLR: assert property (chain_ack[1] && !chain_comp_valid[1] |=> !chain_changed[1])
    else $error("ack did not clear change flag");
  AST_REQ_HOLD: assert property (baseline_request_flag && !baseline_accept |=> baseline_request_flag)
    else $error("baseline request dropped early");
  cover property ($fell(baseline_request_flag));
  cover property ($rose(chain_changed[1]));
  cover property ($fell(system_lockout));
endmodule // lrcb_properties
bind lrcb_manager lrcb_properties chk_i (.*);
`default_nettype wire

// File: lrcb_plc_model.sv
// Purpose: controller model that answers baseline requests and chain changes
// Assumes: same clock as the manager
// Notes: answers DLY+1 cycles after a request is seen; acks only while ack_en is high
`default_nettype none
module lrcb_plc_model #(
  parameter int unsigned DLY = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic baseline_request_flag,
  input wire logic [lrcb_pkg::N_CHAIN-1:0] chain_changed,
  input wire logic ack_en,
  output logic baseline_accept,
  output logic [lrcb_pkg::N_CHAIN-1:0] chain_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  import lrcb_pkg::*;
  logic [7:0] cnt_reg, cnt_next;
  logic acc_next;
  logic [N_CHAIN-1:0] ack_next;
  always_comb begin
    cnt_next = 8'h0;
    acc_next = 1'b0;
    ack_next = '0;
    if (baseline_request_flag || (ack_en && |chain_changed)) begin
      cnt_next = cnt_reg + 8'h1;
      if (cnt_reg == DLY[7:0]) begin
        acc_next = baseline_request_flag;
        ack_next = ack_en ? chain_changed : '0;
        cnt_next = 8'h0;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h0;
      baseline_accept <= 1'b0;
      chain_ack <= '0;
    end else begin
      cnt_reg <= cnt_next;
      baseline_accept <= acc_next;
      chain_ack <= ack_next;
    end
  end
endmodule // lrcb_plc_model
`default_nettype wire

// File: lrcb_manager_tb.sv
// Purpose: self-checking bench for the lockout manager
// Assumes: short debounce of 2 cycles
// Notes: fault rows in a table, awkward cases by hand afterwards
`default_nettype none
module lrcb_manager_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lrcb_pkg::*;
  localparam int unsigned DEB = 2;
  typedef struct packed {logic [4:0] flt; logic [1:0] clr; logic [6:0] lock; logic [1:0] out;} lrcb_row_t;
  lrcb_row_t rows [5] = '{'{5'h10, 2'h0, 7'h40, 2'h0}, '{5'h08, 2'h0, 7'h40, 2'h0},
    '{5'h02, 2'h1, 7'h10, 2'h2}, '{5'h04, 2'h1, 7'h20, 2'h1}, '{5'h01, 2'h2, 7'h01, 2'h0}};
  logic clk_sys = 1'b0, rst = 1'b1, ack_en = 1'b0;
  logic [3:0] input_pin = 4'hf, input_fault = 4'h0, reset_pin = 4'h0, reset_is_system = 4'h1;
  logic [3:0] reset_non_monitored = 4'h0, output_input_map = 4'h1, input_lockout;
  logic [1:0] fault_clear_node_sel_0 = 2'h0, fault_clear_node_sel_1 = 2'h3, output_fault = 2'h0;
  logic [1:0] output_demand = 2'h3, chain_comp_valid = 2'h3, chain_diagnostic_info = 2'h0;
  logic [1:0] chain_ack, safety_switching_output, output_lockout, chain_changed;
  logic sys_fault = 1'b0, press_fault = 1'b0, internal_fault = 1'b0, virtual_reset = 1'b0;
  logic virtual_reset_is_system = 1'b0, config_loaded = 1'b0, chain_auto_discovery = 1'b1;
  logic startup_baseline_confirm = 1'b0, baseline_accept, system_lockout, config_error;
  logic chain_query, baseline_request_flag;
  logic [63:0] chain_comp = 64'h1111_0002_2222_0003, chain_baseline;
  int error_cnt = 0, cmp_count = 0;
  wire [6:0] lk = {system_lockout, output_lockout, input_lockout};
  lrcb_manager #(.DEB_CYC(DEB)) dut (.*);
  lrcb_plc_model #(.DLY(20)) plc (.*);
  always #2.5 clk_sys = ~clk_sys;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // pin held past sync and debounce before release
  task automatic rcyc(input int k);
    @(posedge clk_sys);
    reset_pin[k] <= 1'b1;
    wt(DEB + 8);
    @(posedge clk_sys);
    reset_pin[k] <= 1'b0;
    wt(DEB + 8);
  endtask
  task automatic incyc();
    @(posedge clk_sys);
    input_pin[0] <= 1'b0;
    wt(DEB + 8);
    @(posedge clk_sys);
    input_pin[0] <= 1'b1;
    wt(DEB + 8);
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    wt(12);
    @(posedge clk_sys);
    rst <= 1'b0;
    wt(DEB + 8);
    chk(0, safety_switching_output);
    chk(chain_comp, chain_baseline);
    chk(1, chain_query);
    rcyc(0);
    chk(3, safety_switching_output);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      {sys_fault, press_fault, output_fault, input_fault[0]} <= rows[i].flt;
      wt(2);
      @(posedge clk_sys);
      {sys_fault, press_fault, output_fault, input_fault[0]} <= 5'h0;
      wt(4);
      chk(rows[i].lock, lk);
      chk(rows[i].out, safety_switching_output);
      if (rows[i].clr == 2'h2) incyc(); else rcyc(rows[i].clr);
      chk(0, lk);
    end
    @(posedge clk_sys);
    {press_fault, sys_fault} <= 2'h3;
    @(posedge clk_sys);
    press_fault <= 1'b0;
    rcyc(1);
    chk(7'h40, lk);
    rcyc(0);
    chk(7'h40, lk);
    @(posedge clk_sys);
    {sys_fault, reset_non_monitored} <= 5'h01;
    wt(3);
    @(posedge clk_sys);
    reset_pin[0] <= 1'b1;
    wt(DEB + 8);
    chk(3, safety_switching_output);
    @(posedge clk_sys);
    {reset_pin[0], reset_non_monitored, chain_diagnostic_info} <= 7'h03;
    // both chains change so that each change flag is set and acknowledged
    chain_comp <= 64'h1111_0004_2222_0004;
    wt(6);
    chk(2'h3, chain_changed);
    chk(64'h1111_0004_2222_0004, chain_baseline);
    chk(3, safety_switching_output);
    @(posedge clk_sys);
    {chain_comp_valid, ack_en} <= 3'h1;
    wt(40);
    chk(0, chain_changed);
    @(posedge clk_sys);
    {chain_comp_valid, ack_en, virtual_reset_is_system} <= 4'hf;
    wt(6);
    chk(1, config_error);
    chk(0, safety_switching_output);
    @(posedge clk_sys);
    {reset_is_system, config_loaded, sys_fault} <= 6'h03;
    @(posedge clk_sys);
    {config_loaded, sys_fault, virtual_reset} <= 3'h1;
    wt(DEB + 8);
    @(posedge clk_sys);
    virtual_reset <= 1'b0;
    wt(DEB + 8);
    chk(3, safety_switching_output);
    @(posedge clk_sys);
    {internal_fault, reset_is_system, virtual_reset_is_system} <= 6'h22;
    @(posedge clk_sys);
    internal_fault <= 1'b0;
    rcyc(0);
    chk(1, system_lockout);
    @(posedge clk_sys);
    {rst, startup_baseline_confirm} <= 2'h3;
    chain_comp <= 64'h5555_0004_6666_0005;
    wt(3);
    @(posedge clk_sys);
    rst <= 1'b0;
    wt(DEB + 8);
    chk(1, baseline_request_flag);
    chk(0, chain_changed);
    wt(40);
    chk(0, baseline_request_flag);
    chk(64'h5555_0004_6666_0005, chain_baseline);
    give_verdict();
  end
  // whole run needs about 400 cycles, so 50 us is ample
  initial begin
    #50us;
    error_cnt++;
    give_verdict();
  end
endmodule // lrcb_manager_tb
`default_nettype wire
